/* pdc_pkg.sv */
// Functional notes
// - base saved with context, reloaded on restore
// - base bits 30:16 hold cacheline offset
// - index register selects the word, data register reads cache
// - cache refilled only during context restore
// - restore loads only enabled cachelines
// - index bits 11:2, ten bits, reset zero
// - data read returns indexed cache word
package pdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte offsets)
  localparam logic [15:0] PDC_OFS_INDEX = 16'h2500;  // directory cache index
  localparam logic [15:0] PDC_OFS_DATA  = 16'h2504;  // directory cache data
  localparam logic [15:0] PDC_OFS_BASE  = 16'h2518;  // page directory base

  // writable field masks, everything else reserved
  localparam logic [31:0] PDC_BASE_MASK  = 32'h7FFF_0000;  // bits 30:16
  localparam logic [31:0] PDC_INDEX_MASK = 32'h0000_0FFC;  // bits 11:2

  // reset values
  localparam logic [31:0] PDC_BASE_RESET  = 32'h0000_0000;
  localparam logic [31:0] PDC_INDEX_RESET = 32'h0000_0000;
  localparam logic [31:0] PDC_ZERO_WORD   = 32'h0000_0000;

  // field positions
  localparam int PDC_IDX_LSB   = 2;   // index field low bit
  localparam int PDC_IDX_MSB   = 11;  // index field high bit
  localparam int PDC_LINE_LSB  = 4;   // 16 words per 64-byte cacheline
  localparam int PDC_WORDS     = 1024;
  localparam int PDC_LINES     = 64;

  ////////////////////////////////////////////////////////////////////////////
  // mmio request
  typedef struct packed {
    logic        rd;     // read strobe
    logic        wr;     // write strobe
    logic [15:0] addr;   // byte offset
    logic [31:0] wdata;  // write data
  } pdc_mmio_req_t;

  // restore fill word
  typedef struct packed {
    logic        valid;  // word present this cycle
    logic [9:0]  index;  // cache word index
    logic [31:0] data;   // directory entry
  } pdc_fill_t;

  // restore sequencing
  typedef enum logic {
    ST_IDLE,
    ST_RESTORE
  } pdc_state_t;

endpackage

/* pdc_mmio_decode.sv */
`timescale 1ns/10ps
module pdc_mmio_decode
  import pdc_pkg::*;
(
  // request address
  input  wire logic [15:0] addr,
  // register selects
  output wire logic        hitIndex,
  output wire logic        hitData,
  output wire logic        hitBase
);

  ////////////////////////////////////////////////////////////////////////////
  // full compare, no aliasing of neighbouring words
  assign hitIndex = (addr == PDC_OFS_INDEX);
  assign hitData  = (addr == PDC_OFS_DATA);
  assign hitBase  = (addr == PDC_OFS_BASE);

endmodule

/* pdc_dir_cache.sv */
`timescale 1ns/10ps
module pdc_dir_cache
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // mmio register port
  input  wire pdc_mmio_req_t mmioReq,
  output logic [31:0]        mmioRdata,
  output logic               mmioRdValid,
  // context restore
  input  wire logic          restoreBegin,
  input  wire logic          restoreEnd,
  input  wire logic [31:0]   ctxBase,
  input  wire logic [63:0]   lineEnable,
  input  wire pdc_fill_t     fill,
  // status
  output logic               restoreBusy,
  output logic [31:0]        dirBase
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [31:0] baseReg;                   // page_directory_base_reg
  logic [31:0] baseNext;
  logic [31:0] indexReg;                  // directory_cache_index_reg
  logic [31:0] indexNext;
  logic [63:0] lineEnReg;                 // enables caught at restore start
  logic [31:0] rdataReg;                  // read answer
  logic        rdValidReg;
  pdc_state_t  stateReg;
  pdc_state_t  stateNext;
  logic [31:0] cacheMem [PDC_WORDS];      // on-chip directory cache

  // decode
  logic        hitIndex;
  logic        hitData;
  logic        hitBase;
  logic        wrBase;
  logic        wrIndex;
  logic        cacheWe;
  logic [9:0]  rdIdx;
  logic [5:0]  fillLine;
  logic [31:0] cacheWord;
  logic [31:0] rdMux;

  pdc_mmio_decode u_decode (
    .addr     (mmioReq.addr),
    .hitIndex (hitIndex),
    .hitData  (hitData),
    .hitBase  (hitBase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  assign wrBase  = mmioReq.wr && hitBase;   // debug write, normally unused
  assign wrIndex = mmioReq.wr && hitIndex;

  // restore image wins over a debug write in the same cycle
  assign baseNext = restoreBegin ? (ctxBase & PDC_BASE_MASK)
                  : wrBase       ? (mmioReq.wdata & PDC_BASE_MASK)
                  : baseReg;

  // only the index field is kept
  assign indexNext = wrIndex ? (mmioReq.wdata & PDC_INDEX_MASK) : indexReg;

  // restore sequencing: begin opens the window, end closes it
  assign stateNext = restoreBegin ? ST_RESTORE
                   : restoreEnd   ? ST_IDLE
                   : stateReg;

  ////////////////////////////////////////////////////////////////////////////
  // fill gate: inside restore window and line enabled only
  assign fillLine = fill.index[PDC_IDX_MSB-PDC_IDX_LSB:PDC_LINE_LSB];
  assign cacheWe  = fill.valid && (stateReg == ST_RESTORE)
                 && lineEnReg[fillLine];

  ////////////////////////////////////////////////////////////////////////////
  // read path
  assign rdIdx     = indexReg[PDC_IDX_MSB:PDC_IDX_LSB];
  assign cacheWord = cacheMem[rdIdx];
  // unmapped offsets answer zero
  assign rdMux = hitIndex ? indexReg
               : hitData  ? cacheWord
               : hitBase  ? baseReg
               : PDC_ZERO_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      baseReg    <= PDC_BASE_RESET;
      indexReg   <= PDC_INDEX_RESET;
      stateReg   <= ST_IDLE;
      rdataReg   <= PDC_ZERO_WORD;
      rdValidReg <= 1'b0;
    end else begin
      baseReg    <= baseNext;
      indexReg   <= indexNext;
      stateReg   <= stateNext;
      rdValidReg <= mmioReq.rd;
      if (mmioReq.rd) begin
        rdataReg <= rdMux;
      end
    end
  end

  // enables latched once per restore so mid-restore changes cannot leak in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lineEnReg <= 64'h0000_0000_0000_0000;
    end else if (restoreBegin) begin
      lineEnReg <= lineEnable;
    end
  end

  // cache array, no reset: contents are only meaningful after a restore
  always_ff @(posedge clk) begin
    if (cacheWe) begin
      cacheMem[fill.index] <= fill.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign mmioRdata   = rdataReg;
  assign mmioRdValid = rdValidReg;
  assign restoreBusy = (stateReg == ST_RESTORE);
  assign dirBase     = baseReg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_base_restore;
    @(posedge clk) disable iff (!reset_n)
      restoreBegin |=> (baseReg == ($past(ctxBase) & PDC_BASE_MASK));
  endproperty
  a_base_restore: assert property (p_base_restore)
    else $error("base not reloaded on restore");

  property p_base_field;
    @(posedge clk) disable iff (!reset_n)
      (wrBase && !restoreBegin) |=> (dirBase[30:16] == $past(mmioReq.wdata[30:16]));
  endproperty
  a_base_field: assert property (p_base_field)
    else $error("base offset field wrong");

  property p_read_answer;
    @(posedge clk) disable iff (!reset_n)
      mmioReq.rd |=> mmioRdValid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered next cycle");

  property p_no_fill_idle;
    @(posedge clk) disable iff (!reset_n)
      (stateReg == ST_IDLE) |-> !cacheWe;
  endproperty
  a_no_fill_idle: assert property (p_no_fill_idle)
    else $error("cache written outside restore");

  property p_fill_enabled;
    @(posedge clk) disable iff (!reset_n)
      (fill.valid && restoreBusy && !lineEnReg[fillLine]) |-> !cacheWe;
  endproperty
  a_fill_enabled: assert property (p_fill_enabled)
    else $error("disabled cacheline loaded");

  property p_index_write;
    @(posedge clk) disable iff (!reset_n)
      wrIndex ##1 (mmioReq.rd && hitIndex)
        |=> (mmioRdata[11:2] == $past(mmioReq.wdata[11:2], 2));
  endproperty
  a_index_write: assert property (p_index_write)
    else $error("index readback mismatch");

  property p_data_read;
    @(posedge clk) disable iff (!reset_n)
      (mmioReq.rd && hitData) |=> (mmioRdata == $past(cacheWord));
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data read not indexed word");

  property p_reserved_zero;
    @(posedge clk) disable iff (!reset_n)
      (mmioReq.rd && (hitIndex || hitBase))
        |=> ((mmioRdata & ~(PDC_INDEX_MASK | PDC_BASE_MASK)) == PDC_ZERO_WORD);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

endmodule

/* page_directory_base_and_cache_index_tb.sv */
`timescale 1ns/10ps
module page_directory_base_and_cache_index_tb
  import pdc_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic          clk = 1'b0;    // 20 MHz bench clock
  logic          reset_n;       // async, active low
  pdc_mmio_req_t req;           // register access
  logic [31:0]   rdata;         // read data
  logic          rdValid;       // read answer pulse
  logic          rBegin;        // restore start pulse
  logic          rEnd;          // restore end pulse
  logic [31:0]   ctxBase;       // saved base from image
  logic [63:0]   lineEn;        // cacheline enables
  pdc_fill_t     fw;            // fill word
  logic          busy;          // restore window
  logic [31:0]   dirBase;       // live base value
  int            n_errors  = 0; // mismatches seen
  int            cmp_count = 0; // comparisons made
  logic [31:0]   v;             // scratch read value
  // ordinary cases: write offset, data, expected read back
  logic [15:0]   rowA [4] = '{16'h2500, 16'h2518, 16'h2508, 16'h2500};
  logic [31:0]   rowW [4] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_1234};
  logic [31:0]   rowE [4] = '{32'h0000_0FFC, 32'h7FFF_0000, 32'h0000_0000, 32'h0000_0234};

  always #25 clk = ~clk;

  pdc_dir_cache uut (.clk(clk), .reset_n(reset_n), .mmioReq(req), .mmioRdata(rdata),
    .mmioRdValid(rdValid), .restoreBegin(rBegin), .restoreEnd(rEnd), .ctxBase(ctxBase),
    .lineEnable(lineEn), .fill(fw), .restoreBusy(busy), .dirBase(dirBase));

  ////////////////////////////////////////////////////////////////////////////
  // helpers; inputs always move 1 ns after the rising edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobe is dropped and an edge passes, so no back-to-back reassignment
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    tick();
    req.wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0000_0000};
    tick();
    check(rdValid, 1'b1);
    d = rdata;
    req.rd = 1'b0;
    tick();
    check(rdValid, 1'b0);
  endtask

  // selects a word through the index then reads the data register
  task automatic peek(input logic [9:0] i, input logic [31:0] exp);
    wr(PDC_OFS_INDEX, {20'h0_0000, i, 2'b00});
    rd(PDC_OFS_DATA, v);
    check(v, exp);
  endtask

  task automatic fillw(input logic [9:0] i, input logic [31:0] d);
    fw = '{valid: 1'b1, index: i, data: d};
    tick();
    fw.valid = 1'b0;
    tick();
  endtask

  // restore window with a fill word offered on the opening edge
  task automatic restore(input logic [31:0] b, input logic [63:0] en, input pdc_fill_t f0);
    ctxBase = b;
    lineEn  = en;
    rBegin  = 1'b1;
    fw      = f0;
    tick();
    rBegin   = 1'b0;
    fw.valid = 1'b0;
    check(busy, 1'b1);
    check(dirBase, b & PDC_BASE_MASK);
  endtask

  task automatic close();
    rEnd = 1'b1;
    tick();
    rEnd = 1'b0;
    check(busy, 1'b0);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: fires after 3000 cycles; whole sequence needs well under that
  initial begin
    #(3000 * 50);
    n_errors++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_n = 1'b0;
    req = '0;
    rBegin = 1'b0;
    rEnd = 1'b0;
    ctxBase = 32'h0000_0000;
    lineEn = 64'h0000_0000_0000_0000;
    fw = '0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    tick();
    check(busy, 1'b0);
    check(dirBase, PDC_BASE_RESET);
    rd(PDC_OFS_INDEX, v);
    check(v, PDC_INDEX_RESET);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      wr(rowA[k], rowW[k]);
      rd(rowA[k], v);
      check(v, rowE[k]);
    end
    $display("test register rows done");
    // first restore: all lines on, three words in three lines
    restore(32'hFFFF_FFFF, {64{1'b1}}, '0);
    fillw(10'd5, 32'h1111_0001);
    fillw(10'd20, 32'h2222_0001);
    fillw(10'd1023, 32'h3333_0001); // top index boundary
    close();
    peek(10'd5, 32'h1111_0001);
    peek(10'd1023, 32'h3333_0001);
    $display("test restore fill done");
    // outside window and read-only data register leave the cache alone
    fillw(10'd5, 32'hDEAD_0001);
    wr(PDC_OFS_DATA, 32'hBEEF_0001);
    peek(10'd5, 32'h1111_0001);
    $display("test fill outside window done");
    // second restore: only line 0 on; opening-edge fill refused
    restore(32'h1234_5678, 64'h0000_0000_0000_0001,
      '{valid: 1'b1, index: 10'd5, data: 32'h4444_0001});
    fillw(10'd1023, 32'h5555_0001);
    fillw(10'd20, 32'h6666_0001);
    fillw(10'd6, 32'h7777_0001);
    close();
    peek(10'd5, 32'h1111_0001);
    peek(10'd1023, 32'h3333_0001);
    peek(10'd20, 32'h2222_0001);
    peek(10'd6, 32'h7777_0001);
    rd(PDC_OFS_BASE, v);
    check(v, 32'h1234_0000);
    $display("test line enables done");
    // debug base write on the restore edge loses to the context image
    req = '{rd: 1'b0, wr: 1'b1, addr: PDC_OFS_BASE, wdata: 32'h0ABC_0000};
    restore(32'h0001_0000, 64'h0000_0000_0000_0000, '0);
    req.wr = 1'b0;
    close();
    rd(PDC_OFS_BASE, v);
    check(v, 32'h0001_0000);
    $display("test restore over base write done");
    // back to back: index write, index read, data read on three edges
    req = '{rd: 1'b0, wr: 1'b1, addr: PDC_OFS_INDEX, wdata: 32'h0000_0018};
    tick();
    req = '{rd: 1'b1, wr: 1'b0, addr: PDC_OFS_INDEX, wdata: 32'h0000_0000};
    tick();
    check(rdata, 32'h0000_0018);
    req.addr = PDC_OFS_DATA;
    tick();
    check(rdata, 32'h7777_0001);
    req.rd = 1'b0;
    tick();
    check(rdValid, 1'b0);
    $display("test back to back done");
    summarize();
  end
endmodule
